// >>> verilog/sswc_consts.vh
// Constants for the sense switch control block.
// Assumes inclusion by the design file and the testbench; definitions only.
`ifndef SSWC_CONSTS_VH
`define SSWC_CONSTS_VH

// ----------------------------------------
// Register offsets (word offsets)
// ----------------------------------------
`define SSWC_REG_CTRL      4'h0
`define SSWC_REG_CAL       4'h1
`define SSWC_REG_STATUS    4'h2
`define SSWC_REG_IRQ_STAT  4'h3
`define SSWC_REG_IRQ_MASK  4'h4
`define SSWC_REG_SWITCH    4'h5

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SSWC_CTRL_EMF_EN     0
`define SSWC_CTRL_SH_EN      1
`define SSWC_CTRL_RDSON      2
`define SSWC_CTRL_EXT_TAP    3
`define SSWC_CTRL_EMF_SH     4
`define SSWC_CTRL_GAIN_LO    5
`define SSWC_CTRL_GAIN_HI    6
`define SSWC_CTRL_TGT_LO     8
`define SSWC_CTRL_TGT_HI     11
`define SSWC_CTRL_RESET      12'h000

// ----------------------------------------
// Calibration register fields
// ----------------------------------------
`define SSWC_CAL_REQ_LO      0
`define SSWC_CAL_REQ_HI      2
`define SSWC_CALIBRATE_INPUT_CONNECTION        3

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define SSWC_IRQ_CAL_DONE    0
`define SSWC_IRQ_OC_A        1
`define SSWC_IRQ_OC_B        2
`define SSWC_IRQ_OC_C        3

// ----------------------------------------
// Gain codes and timing
// ----------------------------------------
`define SSWC_GAIN_5          2'h0
`define SSWC_GAIN_10         2'h1
`define SSWC_GAIN_20         2'h2
`define SSWC_GAIN_40         2'h3
`define SSWC_CLK_HZ          25000000
`define SSWC_CAL_TIME_US     768
`define SSWC_CAL_CYCLES      (`SSWC_CAL_TIME_US * (`SSWC_CLK_HZ / 1000000))
`define SSWC_PROP_NS         40
`define SSWC_PROP_CYCLES     ((`SSWC_PROP_NS * (`SSWC_CLK_HZ / 1000000) + 999) / 1000)
`define SSWC_TGT_UNIT_NS     40
`define SSWC_SHORT_CYCLES    4

`endif

// >>> verilog/sswc_sense_switch.v
// Sense switch control: phase select decoding, output mux select,
// on-resistance and sample/hold switch timing, amplifier calibration.
// Assumes one 25 MHz clock, Avalon-MM slave, pins sampled asynchronously.
// Overview of operation
// (RULE1) Phase-select pins 00 none, 01 A, 10 B, 11 C.
// (RULE2) With sample/hold, output pins select held channel A, B, C or none.
// (RULE3) On-resistance mode: sense input closed only while that low-side is on.
// (RULE4) High-voltage sense switch closes after low-side on plus transition time.
// (RULE5) Back-EMF enabled keeps chain link switch to third amplifier closed.
// (RULE6) Back-EMF enabled: third amplifier in EMF chain, two amps sense current.
// (RULE7) Center-tap or virtual-center switch per configuration, never both.
// (RULE8) Single-shunt sample/hold: sense phase A only, phase B overcurrent kept.
// (RULE9) No EMF, no sample/hold: three currents pass continuously, unswitched.
// (RULE10) Four gain settings 5, 10, 20, 40 V/V.
// (RULE11) Calibrate all three amplifiers automatically after reset.
// (RULE12) Calibration opens inputs, shorts them, gain 40, then auto-zero.
// (RULE13) Software calibration bits calibrate each selected amplifier, several at once.
// (RULE14) Three-amplifier calibration takes about 768 us.
// (RULE15) Connection bit: shorted inputs or inputs left on external shunt.
// (RULE16) Overcurrent monitored on every amplifier regardless of sample/hold.
// (RULE17) Sample switch closes after 40 ns plus transition time, opens on gate-off.
// (RULE18) Select pins synchronised before decoding.
`timescale 1ns/1ps
`include "sswc_consts.vh"

module sswc_sense_switch #(
	parameter CAL_CYCLES = `SSWC_CAL_CYCLES
) (
	input  wire        core_clk_i,
	input  wire        rst_i,
	input  wire [3:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o,
	input  wire        phase_select_bit1_i,
	input  wire        phase_select_bit2_i,
	input  wire        third_output_or_select1_i,
	input  wire        second_output_or_select2_i,
	input  wire [2:0]  low_side_on_i,
	input  wire [2:0]  gate_drive_on_i,
	input  wire [2:0]  overcurrent_i,
	output reg  [2:0]  phase_emf_switch_o,
	output reg  [2:0]  mux_channel_o,
	output reg  [2:0]  sense_input_switch_o,
	output reg  [2:0]  high_voltage_sense_switch_o,
	output reg  [2:0]  sample_switch_o,
	output reg         emf_chain_link_switch_o,
	output reg         center_tap_switch_o,
	output reg         virtual_center_switch_o,
	output reg  [2:0]  amp_current_enable_o,
	output reg  [2:0]  cal_short_o,
	output reg  [2:0]  autozero_o,
	output reg  [1:0]  gain_o,
	output reg         irq_o
);

// ----------------------------------------
// Helpers
// ----------------------------------------
	// One-hot decode shared by phase and mux selects
	function [2:0] sel_decode;
		input [1:0] code;
		begin
			case (code)
				2'h1:    sel_decode = 3'h1;
				2'h2:    sel_decode = 3'h2;
				2'h3:    sel_decode = 3'h4;
				default: sel_decode = 3'h0;
			endcase
		end
	endfunction

	localparam ST_IDLE  = 3'h1;
	localparam ST_SHORT = 3'h2;
	localparam ST_ZERO  = 3'h4;

// ----------------------------------------
// Registers and bus slave
// ----------------------------------------
	reg  [11:0] ctrl;
	reg  [2:0]  cal_req;
	reg         calibrate_input_connection;
	reg  [3:0]  irq_stat;
	reg  [3:0]  irq_mask;
	reg  [2:0]  cal_pend;
	reg  [2:0]  cal_cur;
	reg  [2:0]  cal_state;
	reg  [15:0] cal_cnt;
	reg         cal_done_ev;
	reg         bus_ack;

	wire        emf_en  = ctrl[`SSWC_CTRL_EMF_EN];
	wire        sh_en   = ctrl[`SSWC_CTRL_SH_EN];
	wire        rdson   = ctrl[`SSWC_CTRL_RDSON];
	wire        ext_tap = ctrl[`SSWC_CTRL_EXT_TAP];
	wire        emf_sh  = ctrl[`SSWC_CTRL_EMF_SH];
	wire [3:0]  tgt     = ctrl[`SSWC_CTRL_TGT_HI:`SSWC_CTRL_TGT_LO];
	wire        bus_req = (avs_read_i | avs_write_i) & ~bus_ack;
	wire        bus_wr  = bus_ack & avs_write_i;
	wire        wr_cal  = bus_wr & (avs_address_i == `SSWC_REG_CAL);
	wire [2:0]  oc_ev;
	wire [3:0]  events  = {oc_ev, cal_done_ev};

	// Waitrequest drops for one cycle: every access takes two edges
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_ack           <= 1'b0;
			avs_waitrequest_o <= 1'b1;
		end else begin
			bus_ack           <= bus_req;
			avs_waitrequest_o <= ~bus_req;
		end
	end

// ----------------------------------------
// Control and mask registers
// ----------------------------------------
	// Writes land at the edge that sees waitrequest low, never earlier
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl     <= `SSWC_CTRL_RESET;
			calibrate_input_connection <= 1'b0;
			irq_mask <= 4'h0;
		end else if (bus_wr) begin
			case (avs_address_i)
				`SSWC_REG_CTRL:     ctrl <= avs_writedata_i[11:0];
				// (RULE15) Connection choice
				`SSWC_REG_CAL:      calibrate_input_connection <= avs_writedata_i[`SSWC_CALIBRATE_INPUT_CONNECTION];
				`SSWC_REG_IRQ_MASK: irq_mask <= avs_writedata_i[3:0];
				default:            ;
			endcase
		end
	end

// ----------------------------------------
// Interrupt status and line
// ----------------------------------------
	// Set wins over write-one-to-clear, so no event is lost
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat <= 4'h0;
			irq_o    <= 1'b0;
		end else begin
			if (bus_wr && (avs_address_i == `SSWC_REG_IRQ_STAT))
				irq_stat <= (irq_stat & ~avs_writedata_i[3:0]) | events;
			else
				irq_stat <= irq_stat | events;
			irq_o <= |(irq_stat & irq_mask);
		end
	end

// ----------------------------------------
// Read data
// ----------------------------------------
	// Loaded on the request edge so it stands while waitrequest is low
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0;
		end else if (bus_req & avs_read_i) begin
			case (avs_address_i)
				`SSWC_REG_CTRL:     avs_readdata_o <= {20'h0, ctrl};
				`SSWC_REG_CAL:      avs_readdata_o <= {28'h0, calibrate_input_connection, cal_pend | cal_cur};
				`SSWC_REG_STATUS:   avs_readdata_o <= {24'h0, cal_state, 2'h0, cal_cur};
				`SSWC_REG_IRQ_STAT: avs_readdata_o <= {28'h0, irq_stat};
				`SSWC_REG_IRQ_MASK: avs_readdata_o <= {28'h0, irq_mask};
				`SSWC_REG_SWITCH:   avs_readdata_o <= {26'h0, sample_switch_o,
					phase_emf_switch_o};
				default:            avs_readdata_o <= 32'h0;
			endcase
		end else begin
			avs_readdata_o <= 32'h0;
		end
	end

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
	// Three stages; a change counts only when stages two and three agree
	reg [3:0] pin_s1;
	reg [3:0] pin_s2;
	reg [3:0] pin_s3;
	reg [3:0] pin_val;
	reg [2:0] oc_s1;
	reg [2:0] oc_s2;
	reg [2:0] oc_s3;
	reg [2:0] oc_prev;

	// (RULE18) Select pins synchronised
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1  <= 4'h0;
			pin_s2  <= 4'h0;
			pin_s3  <= 4'h0;
			pin_val <= 4'h0;
			oc_s1   <= 3'h0;
			oc_s2   <= 3'h0;
			oc_s3   <= 3'h0;
			oc_prev <= 3'h0;
		end else begin
			pin_s1 <= {phase_select_bit1_i, phase_select_bit2_i,
				third_output_or_select1_i, second_output_or_select2_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_val <= (pin_s2 & pin_s3) | (pin_val & (pin_s2 | pin_s3));
			oc_s1  <= overcurrent_i;
			oc_s2  <= oc_s1;
			oc_s3  <= oc_s2;
			oc_prev <= oc_s3;
		end
	end

	// (RULE16) Overcurrent edges on every amplifier, any mode
	assign oc_ev = oc_s2 & oc_s3 & ~oc_prev;

// ----------------------------------------
// Switch timing per phase
// ----------------------------------------
	// Delay counters cover propagation plus transition time
	reg  [5:0] ls_cnt [0:2];
	reg  [5:0] gd_cnt [0:2];
	wire [31:0] tgt_sum = {28'h0, tgt} + `SSWC_PROP_CYCLES;
	wire [5:0] tgt_cyc = tgt_sum[5:0];
	integer    p;

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (p = 0; p < 3; p = p + 1) begin
				ls_cnt[p] <= 6'h0;
				gd_cnt[p] <= 6'h0;
			end
			high_voltage_sense_switch_o <= 3'h0;
			sample_switch_o             <= 3'h0;
		end else begin
			for (p = 0; p < 3; p = p + 1) begin
				// (RULE4) Close after on plus transition time
				if (!low_side_on_i[p] || !rdson || cal_cur[p]) begin
					ls_cnt[p] <= 6'h0;
					high_voltage_sense_switch_o[p] <= 1'b0;
				end else if (ls_cnt[p] < tgt_cyc) begin
					ls_cnt[p] <= ls_cnt[p] + 6'h1;
				end else begin
					high_voltage_sense_switch_o[p] <= 1'b1;
				end
				// (RULE17) Sample closes late, opens on gate-off
				if (!gate_drive_on_i[p] || !(sh_en || emf_sh)) begin
					gd_cnt[p] <= 6'h0;
					sample_switch_o[p] <= 1'b0;
				end else if (gd_cnt[p] < tgt_cyc) begin
					gd_cnt[p] <= gd_cnt[p] + 6'h1;
				end else begin
					sample_switch_o[p] <= 1'b1;
				end
			end
		end
	end

// ----------------------------------------
// Calibration sequencer
// ----------------------------------------
	reg [2:0] next_pend;

	always @* begin
		next_pend = cal_pend;
		// (RULE13) Any subset of amplifiers
		if (wr_cal)
			next_pend = cal_pend | avs_writedata_i[`SSWC_CAL_REQ_HI:`SSWC_CAL_REQ_LO];
	end

	// Several requested amplifiers calibrate together, sharing one slot
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// (RULE11) All three after reset
			cal_pend    <= 3'h7;
			cal_cur     <= 3'h0;
			cal_state   <= ST_IDLE;
			cal_cnt     <= 16'h0;
			cal_done_ev <= 1'b0;
		end else begin
			cal_done_ev <= 1'b0;
			case (cal_state)
				ST_IDLE: begin
					cal_pend <= next_pend;
					if (next_pend != 3'h0) begin
						cal_cur   <= next_pend;
						cal_pend  <= 3'h0;
						cal_cnt   <= 16'h0;
						cal_state <= ST_SHORT;
					end
				end
				// (RULE12) Inputs shorted, then auto-zero
				ST_SHORT: begin
					cal_pend <= next_pend;
					cal_cnt  <= cal_cnt + 16'h1;
					if (cal_cnt == `SSWC_SHORT_CYCLES - 1) begin
						cal_cnt   <= 16'h0;
						cal_state <= ST_ZERO;
					end
				end
				// (RULE14) Auto-zero length
				ST_ZERO: begin
					cal_pend <= next_pend;
					cal_cnt  <= cal_cnt + 16'h1;
					if (cal_cnt == CAL_CYCLES[15:0] - 16'h1) begin
						cal_cur     <= 3'h0;
						cal_done_ev <= 1'b1;
						cal_state   <= ST_IDLE;
					end
				end
				default: cal_state <= ST_IDLE;
			endcase
		end
	end

// ----------------------------------------
// Select decode
// ----------------------------------------
	// Pins pass the synchroniser first, so no decode glitch reaches a switch
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_emf_switch_o <= 3'h0;
			mux_channel_o      <= 3'h0;
		end else begin
			// (RULE1) Phase decode
			phase_emf_switch_o <= emf_en ? sel_decode(pin_val[3:2]) : 3'h0;
			// (RULE2) Mux select pins
			mux_channel_o <= (sh_en || emf_sh) ? sel_decode(pin_val[1:0]) : 3'h0;
		end
	end

// ----------------------------------------
// Sense path switches
// ----------------------------------------
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sense_input_switch_o    <= 3'h0;
			emf_chain_link_switch_o <= 1'b0;
			center_tap_switch_o     <= 1'b0;
			virtual_center_switch_o <= 1'b0;
			amp_current_enable_o    <= 3'h0;
		end else begin
			// (RULE3) (RULE9) Switched or continuous inputs, opened for calibration
			sense_input_switch_o <= ~cal_cur & (rdson ? low_side_on_i : 3'h7);
			// (RULE5) Chain link held closed
			emf_chain_link_switch_o <= emf_en;
			// (RULE7) Exclusive neutral reference
			center_tap_switch_o     <= emf_en & ext_tap;
			virtual_center_switch_o <= emf_en & ~ext_tap;
			// (RULE6) (RULE8) Current amplifiers in use
			if (emf_en && sh_en && emf_sh && !rdson)
				amp_current_enable_o <= 3'h1;
			else if (emf_en)
				amp_current_enable_o <= 3'h3;
			else
				amp_current_enable_o <= 3'h7;
		end
	end

// ----------------------------------------
// Calibration outputs
// ----------------------------------------
	// Gain override follows the active set, so it spans short and auto-zero
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cal_short_o <= 3'h0;
			autozero_o  <= 3'h0;
			gain_o      <= `SSWC_GAIN_5;
		end else begin
			// (RULE15) Short only when not left on shunt
			cal_short_o <= (cal_state == ST_IDLE || calibrate_input_connection) ? 3'h0 : cal_cur;
			autozero_o  <= (cal_state == ST_ZERO) ? cal_cur : 3'h0;
			// (RULE10) (RULE12) Gain, forced to 40 while calibrating
			gain_o <= (cal_cur != 3'h0) ? `SSWC_GAIN_40
				: ctrl[`SSWC_CTRL_GAIN_HI:`SSWC_CTRL_GAIN_LO];
		end
	end

endmodule

// >>> sim/sswc_sense_switch_sva.sv
// Checker for the sense switch block: decode, switch timing, calibration.
// Assumes it is bound onto sswc_sense_switch; one clock, reset active high.
`timescale 1ns/1ps
module sswc_sense_switch_chk (
	input wire       core_clk_i,
	input wire       rst_i,
	input wire       avs_waitrequest_o,
	input wire [2:0] low_side_on_i,
	input wire [2:0] gate_drive_on_i,
	input wire [2:0] phase_emf_switch_o,
	input wire [2:0] mux_channel_o,
	input wire [2:0] high_voltage_sense_switch_o,
	input wire [2:0] sample_switch_o,
	input wire       emf_chain_link_switch_o,
	input wire       center_tap_switch_o,
	input wire       virtual_center_switch_o,
	input wire [2:0] amp_current_enable_o,
	input wire [2:0] cal_short_o,
	input wire [2:0] autozero_o,
	input wire [1:0] gain_o
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	sequence short_run;
		(|cal_short_o)[*3];
	endsequence
	cal_start_a: assert property ($fell(rst_i) |-> ##[1:4] cal_short_o == 3'h7)
		else $error("no calibration after reset");
	cal_steps_a: assert property ($rose(|cal_short_o) |-> short_run ##[1:3] (|autozero_o))
		else $error("auto-zero does not follow short");
	cal_gain_a: assert property ((|cal_short_o) || (|autozero_o) |-> gain_o == 2'h3)
		else $error("gain not forced during calibration");
	chain_amp_a: assert property (emf_chain_link_switch_o |-> !amp_current_enable_o[2])
		else $error("third amplifier still on current");
	emf_gate_a: assert property (!emf_chain_link_switch_o |-> phase_emf_switch_o == 3'h0)
		else $error("emf switch closed without chain link");
	tap_excl_a: assert property (!(center_tap_switch_o && virtual_center_switch_o))
		else $error("both neutral switches closed");
	phase_onehot_a: assert property ($onehot0(phase_emf_switch_o))
		else $error("several phase switches closed");
	mux_onehot_a: assert property ($onehot0(mux_channel_o))
		else $error("several mux channels closed");
	hv_delay_a: assert property (!(|(high_voltage_sense_switch_o &
		~$past(high_voltage_sense_switch_o) & ~$past(low_side_on_i, 2))))
		else $error("high voltage switch closed early");
	sample_delay_a: assert property (!(|(sample_switch_o &
		~$past(sample_switch_o) & ~$past(gate_drive_on_i, 2))))
		else $error("sample switch closed early");
	ack_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("ack longer than one cycle");
endmodule
bind sswc_sense_switch sswc_sense_switch_chk i_chk (.core_clk_i, .rst_i, .avs_waitrequest_o,
	.low_side_on_i, .gate_drive_on_i, .phase_emf_switch_o, .mux_channel_o,
	.high_voltage_sense_switch_o, .sample_switch_o, .emf_chain_link_switch_o,
	.center_tap_switch_o, .virtual_center_switch_o, .amp_current_enable_o,
	.cal_short_o, .autozero_o, .gain_o);

// >>> sim/sswc_mcu_model.sv
// Motor controller model: select pins, gate commands, overcurrent levels.
// Assumes the bench calls its tasks; all changes land just after an edge.
`timescale 1ns/1ps
module sswc_mcu_model (
	input  wire       core_clk_i,
	output reg        phase_select_bit1_o = 1'b0,
	output reg        phase_select_bit2_o = 1'b0,
	output reg        mux_select_bit1_o   = 1'b0,
	output reg        mux_select_bit2_o   = 1'b0,
	output reg  [2:0] low_side_on_o       = 3'h0,
	output reg  [2:0] gate_drive_on_o     = 3'h0,
	output reg  [2:0] overcurrent_o       = 3'h0
);
	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	task set_phase(input [1:0] c);
		begin
			@(posedge core_clk_i);
			{phase_select_bit1_o, phase_select_bit2_o} <= c;
		end
	endtask
	task set_mux(input [1:0] c);
		begin
			@(posedge core_clk_i);
			{mux_select_bit1_o, mux_select_bit2_o} <= c;
		end
	endtask
	// Low-side, gate and overcurrent levels set together after one edge
	task set_drive(input [2:0] ls, input [2:0] gd, input [2:0] oc);
		begin
			@(posedge core_clk_i);
			low_side_on_o <= ls;
			gate_drive_on_o <= gd;
			overcurrent_o <= oc;
		end
	endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the sense switch block via its register bus.
// Assumes the controller model drives pins; offsets from the shared header.
`timescale 1ns/1ps
`include "sswc_consts.vh"
`define CHK(a, e) begin comparisons = comparisons + 1; if ((a) !== (e)) begin \
	n_fail = n_fail + 1; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
	reg         clk         = 1'b0;
	reg         rst         = 1'b1;
	reg  [3:0]  adr         = 4'h0;
	reg         rd          = 1'b0;
	reg         wr          = 1'b0;
	reg  [31:0] wd          = 32'h0;
	reg  [31:0] q;
	integer     n_fail      = 0;
	integer     comparisons = 0;
	integer     i;
	wire [31:0] rdata;
	wire        wreq, ps1, ps2, ms1, ms2, lnk, ctap, vtap, irq;
	wire [2:0]  ls, gd, oc, ph, mux, sw, hv, ss, amp, cs, az;
	wire [1:0]  gain;
	always #20 clk = ~clk;
	sswc_mcu_model i_mcu (.core_clk_i(clk), .phase_select_bit1_o(ps1),
		.phase_select_bit2_o(ps2), .mux_select_bit1_o(ms1), .mux_select_bit2_o(ms2),
		.low_side_on_o(ls), .gate_drive_on_o(gd), .overcurrent_o(oc));
	sswc_sense_switch #(.CAL_CYCLES(20)) i_dut (.core_clk_i(clk), .rst_i(rst),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .phase_select_bit1_i(ps1),
		.phase_select_bit2_i(ps2), .third_output_or_select1_i(ms1),
		.second_output_or_select2_i(ms2), .low_side_on_i(ls), .gate_drive_on_i(gd),
		.overcurrent_i(oc), .phase_emf_switch_o(ph), .mux_channel_o(mux),
		.sense_input_switch_o(sw), .high_voltage_sense_switch_o(hv), .sample_switch_o(ss),
		.emf_chain_link_switch_o(lnk), .center_tap_switch_o(ctap),
		.virtual_center_switch_o(vtap), .amp_current_enable_o(amp), .cal_short_o(cs),
		.autozero_o(az), .gain_o(gain), .irq_o(irq));
	// ----------------------------------------
	// Bus and closing tasks
	// ----------------------------------------
	task stop_test;
		begin
			$display("comparisons %0d n_fail %0d", comparisons, n_fail);
			if (n_fail == 0 && comparisons > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		integer k;
		begin
			@(posedge clk);
			adr <= a;
			wd <= d;
			rd <= !w;
			wr <= w;
			k = 0;
			do begin
				@(posedge clk);
				k = k + 1;
			end while (wreq !== 1'b0 && k < 20);
			q = rdata;
			rd <= 1'b0;
			wr <= 1'b0;
			if (k >= 20) begin
				n_fail = n_fail + 1;
				stop_test;
			end
		end
	endtask
	task wait_idle;
		integer k;
		begin
			k = 0;
			do begin
				bus(0, `SSWC_REG_STATUS, 0);
				k = k + 1;
			end while (q[5] !== 1'b1 && k < 60);
			`CHK(q[7:5], 3'h1)
			if (q[5] !== 1'b1)
				stop_test;
		end
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_fail = n_fail + 1;
		stop_test;
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		wait_idle;
		bus(0, `SSWC_REG_IRQ_STAT, 0);
		`CHK(q[0], 1'b1)
		bus(0, `SSWC_REG_CTRL, 0);
		`CHK(q[11:0], `SSWC_CTRL_RESET)
		`CHK(amp, 3'h7)
		bus(0, 4'hf, 0);
		`CHK(q, 32'h0)
		for (i = 0; i < 4; i = i + 1) begin
			bus(1, `SSWC_REG_CTRL, i << 5);
			repeat (2) @(posedge clk);
			`CHK(gain, i[1:0])
		end
		bus(1, `SSWC_REG_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		`CHK({lnk, amp, ctap, vtap}, 6'h2d)
		bus(1, `SSWC_REG_CTRL, 32'h9);
		repeat (2) @(posedge clk);
		`CHK({ctap, vtap}, 2'h2)
		for (i = 0; i < 4; i = i + 1) begin
			i_mcu.set_phase(i[1:0]);
			repeat (8) @(posedge clk);
			`CHK(ph, (i == 0) ? 3'h0 : 3'h1 << (i - 1))
		end
		bus(0, `SSWC_REG_SWITCH, 0);
		`CHK(q[2:0], 3'h4)
		bus(1, `SSWC_REG_CTRL, 32'h2);
		for (i = 0; i < 4; i = i + 1) begin
			i_mcu.set_mux(i[1:0]);
			repeat (8) @(posedge clk);
			`CHK(mux, (i == 0) ? 3'h0 : 3'h1 << (i - 1))
		end
		bus(1, `SSWC_REG_CTRL, 32'h13);
		repeat (2) @(posedge clk);
		`CHK(amp, 3'h1)
		bus(1, `SSWC_REG_IRQ_MASK, 32'h4);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		i_mcu.set_drive(3'h0, 3'h0, 3'h2);
		repeat (6) @(posedge clk);
		`CHK(irq, 1'b1)
		bus(0, `SSWC_REG_IRQ_STAT, 0);
		`CHK(q[3:0], 4'h5)
		i_mcu.set_drive(3'h0, 3'h0, 3'h0);
		bus(1, `SSWC_REG_IRQ_STAT, 32'h4);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		bus(1, `SSWC_REG_CTRL, 32'h304);
		i_mcu.set_drive(3'h1, 3'h0, 3'h0);
		repeat (3) @(posedge clk);
		`CHK({sw[1:0], hv[0]}, 3'h2)
		repeat (6) @(posedge clk);
		`CHK(hv, 3'h1)
		i_mcu.set_drive(3'h0, 3'h0, 3'h0);
		repeat (3) @(posedge clk);
		`CHK({sw[0], hv}, 4'h0)
		bus(1, `SSWC_REG_CTRL, 32'h202);
		i_mcu.set_drive(3'h0, 3'h2, 3'h0);
		repeat (3) @(posedge clk);
		`CHK(ss, 3'h0)
		repeat (6) @(posedge clk);
		bus(0, `SSWC_REG_SWITCH, 0);
		`CHK(q[5:3], 3'h2)
		i_mcu.set_drive(3'h0, 3'h0, 3'h0);
		repeat (3) @(posedge clk);
		`CHK(ss, 3'h0)
		bus(1, `SSWC_REG_IRQ_STAT, 32'hf);
		bus(1, `SSWC_REG_IRQ_MASK, 32'h1);
		bus(1, `SSWC_REG_CAL, 32'hd);
		repeat (2) @(posedge clk);
		`CHK({cs, gain, sw}, 8'h1a)
		bus(0, `SSWC_REG_CAL, 0);
		`CHK(q[3:0], 4'hd)
		wait_idle;
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		bus(1, `SSWC_REG_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		bus(1, `SSWC_REG_CAL, 32'h5);
		repeat (2) @(posedge clk);
		`CHK({cs, gain}, 5'h17)
		repeat (6) @(posedge clk);
		`CHK({cs, az}, 6'h2d)
		wait_idle;
		`CHK({cs, az, gain}, 8'h00)
		stop_test;
	end
endmodule
